// file: adccal_defines.vh
`ifndef ADCCAL_DEFINES_VH
`define ADCCAL_DEFINES_VH

`define ADCCAL_CLK_MHZ 25
`define ADCCAL_SCLK_HALF_NS 160
`define ADCCAL_SCLK_HALF_CYC ((`ADCCAL_SCLK_HALF_NS * `ADCCAL_CLK_MHZ + 999) / 1000)
`define ADCCAL_OUT_PERIOD_US 1000
`define ADCCAL_OUT_PERIOD_CYC (`ADCCAL_OUT_PERIOD_US * `ADCCAL_CLK_MHZ)

`define ADCCAL_WORD_W 24
`define ADCCAL_FIFO_DEPTH 8
`define ADCCAL_FIFO_AW 3

`define ADCCAL_CTRL_RESET 24'h000000
`define ADCCAL_CTRL_MODE_HI 23
`define ADCCAL_CTRL_MODE_LO 21
`define ADCCAL_CTRL_WL24_BIT 20
`define ADCCAL_CTRL_CALRD_BIT 19
`define ADCCAL_CTRL_CALFS_BIT 18

`define ADCCAL_MODE_NORMAL 3'h0
`define ADCCAL_MODE_SELF 3'h1
`define ADCCAL_MODE_SYS_ZERO 3'h2
`define ADCCAL_MODE_SYS_FULL 3'h3
`define ADCCAL_MODE_SYS_OFFSET 3'h4
`define ADCCAL_MODE_BACKGROUND 3'h5

`define ADCCAL_DUR_SELF 4'h9
`define ADCCAL_DUR_SYS_STEP 4'h4
`define ADCCAL_DUR_BACKGROUND 4'h6

`define ADCCAL_BITS_16 5'h10
`define ADCCAL_BITS_24 5'h18

`endif

// file: adccal_fifo.v
`timescale 1ns/10ps
module adccal_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;
reg not_full;
wire push;
wire pop;
localparam [31:0] LAST_W = DEPTH - 1;

// Kept in a flop so the ready output needs no decode after the count
assign in_ready = not_full;
assign out_valid = (count != {(AW+1){1'b0}});
assign out_data = mem[rd_ptr];
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

always @(posedge core_clk)
begin
    if (push)
    begin
        mem[wr_ptr] <= in_data;
    end
end

always @(posedge core_clk)
begin
    if (!reset_n)
    begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        count <= {(AW+1){1'b0}};
        not_full <= 1'b1;
    end
    else
    begin
        if (push)
        begin
            wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
        end
        if (pop)
        begin
            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        end
        if (push && !pop)
        begin
            count <= count + {{AW{1'b0}}, 1'b1};
            not_full <= (count != LAST_W[AW:0]);
        end
        else if (pop && !push)
        begin
            count <= count - {{AW{1'b0}}, 1'b1};
            not_full <= 1'b1;
        end
    end
end

endmodule

// file: adccal_rate_div.v
`timescale 1ns/10ps
module adccal_rate_div #(
    parameter PERIOD = 25000
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // One-cycle pulse per output-rate period
    output reg tick
);

reg [31:0] cnt;

always @(posedge core_clk)
begin
    if (!reset_n)
    begin
        cnt <= 32'h00000000;
        tick <= 1'b0;
    end
    else if (cnt == PERIOD - 1)
    begin
        cnt <= 32'h00000000;
        tick <= 1'b1;
    end
    else
    begin
        cnt <= cnt + 32'h00000001;
        tick <= 1'b0;
    end
end

endmodule

// file: adccal_ctrl.v
// Notes on behaviour
// - Mode field selects one of five calibrations
// - Self and offset calibration take nine periods
// - Each system calibration step takes four periods
// - Background calibration: internal points, six periods
// - Reset loads control register with known value
// - Mode pin high: device drives serial clock
// - Select low reads control, high output/calibration
// - Ready flag falls when new word stored
// - Ready flag rises after last output bit
// - Unread words keep overwriting; flag stays low
// - Word arriving during output read is dropped
// - Control or calibration reads leave flag alone
// - Output-read frame start with flag high transfers nothing
// - Frame start enables clock, presents MSB
// - Bits change on falling clock edges
// - Falling edge after LSB: release; flag high after output read
// - Writes only to control or calibration registers
// - Calibration completion pulls ready flag low, except background
`timescale 1ns/10ps
`include "adccal_defines.vh"
module adccal_ctrl #(
    parameter OUT_PERIOD_CYC = `ADCCAL_OUT_PERIOD_CYC
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Host serial pins
    input wire read_frame_strobe_n,
    input wire register_select,
    input wire mode_pin,
    output reg sclk_out,
    output reg sclk_oe,
    output reg serial_data_out,
    output reg serial_data_oe,
    output reg sample_ready_n,
    // Register write path
    input wire reg_wr_en,
    input wire reg_wr_sel,
    input wire [23:0] reg_wr_data,
    // Converter results
    input wire result_valid,
    input wire [23:0] result_data,
    output wire result_ready,
    // Calibration measurements
    input wire [23:0] cal_zero_value,
    input wire [23:0] cal_full_value,
    // Status
    output reg [23:0] ctrl_reg,
    output reg cal_busy,
    output reg cal_zero_phase,
    output reg cal_internal_src
);

localparam integer SCLK_HALF_CYC = `ADCCAL_SCLK_HALF_CYC;
localparam [31:0] HALF_LAST_W = SCLK_HALF_CYC - 1;
localparam [2:0] HALF_LAST = HALF_LAST_W[2:0];
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_SHIFT = 2'h1;
localparam [1:0] ST_HOLD = 2'h2;

////////////////////////////////////////////////////////////////////////

reg rfs_meta;
reg rfs_sync;
reg rfs_prev;
reg sel_meta;
reg sel_sync;
reg mode_meta;
reg mode_sync;
reg [23:0] out_reg;
reg [23:0] cal_offset;
reg [23:0] cal_gain;
reg [3:0] cal_left;
reg [3:0] cal_total;
reg [2:0] cal_mode;
reg [1:0] state;
reg [4:0] bit_cnt;
reg [4:0] bit_total;
reg [23:0] shift;
reg out_read;
reg [2:0] half_cnt;
wire rate_tick;
wire fifo_valid;
wire [23:0] fifo_data;
wire rfs_fall;
wire [2:0] wr_mode;
wire cal_start;
wire cal_done;
wire new_word;
wire wl24;
reg [3:0] next_cal_total;

assign rfs_fall = rfs_prev && !rfs_sync;
assign wl24 = ctrl_reg[`ADCCAL_CTRL_WL24_BIT];
assign wr_mode = reg_wr_data[`ADCCAL_CTRL_MODE_HI:`ADCCAL_CTRL_MODE_LO];

////////////////////////////////////////////////////////////////////////

// Host pins pass two flops before use
always @(posedge core_clk)
begin
    if (!reset_n)
    begin
        rfs_meta <= 1'b1;
        rfs_sync <= 1'b1;
        rfs_prev <= 1'b1;
        sel_meta <= 1'b0;
        sel_sync <= 1'b0;
        mode_meta <= 1'b0;
        mode_sync <= 1'b0;
    end
    else
    begin
        rfs_meta <= read_frame_strobe_n;
        rfs_sync <= rfs_meta;
        rfs_prev <= rfs_sync;
        sel_meta <= register_select;
        sel_sync <= sel_meta;
        mode_meta <= mode_pin;
        mode_sync <= mode_meta;
    end
end

adccal_rate_div #(
    .PERIOD(OUT_PERIOD_CYC)
) u_rate (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tick(rate_tick)
);

// Drained once per output period, so a fast source really fills it
adccal_fifo #(
    .WIDTH(`ADCCAL_WORD_W),
    .DEPTH(`ADCCAL_FIFO_DEPTH),
    .AW(`ADCCAL_FIFO_AW)
) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .in_data(result_data),
    .out_valid(fifo_valid),
    .out_ready(rate_tick),
    .out_data(fifo_data)
);

////////////////////////////////////////////////////////////////////////

assign cal_start = reg_wr_en && !reg_wr_sel && (wr_mode != `ADCCAL_MODE_NORMAL) &&
    (wr_mode <= `ADCCAL_MODE_BACKGROUND);
assign cal_done = cal_busy && rate_tick && (cal_left == 4'h1);
// Results are dropped while calibrating and during an output read
assign new_word = rate_tick && fifo_valid && !cal_busy && !(state == ST_SHIFT && out_read);

always @*
begin
    next_cal_total = `ADCCAL_DUR_SELF;
    case (wr_mode)
        `ADCCAL_MODE_SELF: next_cal_total = `ADCCAL_DUR_SELF;
        `ADCCAL_MODE_SYS_OFFSET: next_cal_total = `ADCCAL_DUR_SELF;
        `ADCCAL_MODE_SYS_ZERO: next_cal_total = `ADCCAL_DUR_SYS_STEP;
        `ADCCAL_MODE_SYS_FULL: next_cal_total = `ADCCAL_DUR_SYS_STEP;
        `ADCCAL_MODE_BACKGROUND: next_cal_total = `ADCCAL_DUR_BACKGROUND;
        default: next_cal_total = `ADCCAL_DUR_SELF;
    endcase
end

// Register writes and calibration sequencing
always @(posedge core_clk)
begin
    if (!reset_n)
    begin
        ctrl_reg <= `ADCCAL_CTRL_RESET;
        cal_offset <= 24'h000000;
        cal_gain <= 24'h000000;
        out_reg <= 24'h000000;
        cal_busy <= 1'b0;
        cal_left <= 4'h0;
        cal_total <= 4'h0;
        cal_mode <= `ADCCAL_MODE_NORMAL;
        cal_zero_phase <= 1'b0;
        cal_internal_src <= 1'b0;
    end
    else
    begin
        if (reg_wr_en && !reg_wr_sel)
        begin
            ctrl_reg <= reg_wr_data;
        end
        else if (reg_wr_en && reg_wr_sel && ctrl_reg[`ADCCAL_CTRL_CALFS_BIT])
        begin
            cal_gain <= reg_wr_data;
        end
        else if (reg_wr_en && reg_wr_sel)
        begin
            cal_offset <= reg_wr_data;
        end
        if (new_word)
        begin
            out_reg <= fifo_data;
        end
        if (cal_start)
        begin
            cal_busy <= 1'b1;
            cal_mode <= wr_mode;
            cal_left <= next_cal_total;
            cal_total <= next_cal_total;
        end
        else if (cal_done)
        begin
            cal_busy <= 1'b0;
            cal_left <= 4'h0;
            if (cal_mode != `ADCCAL_MODE_SYS_FULL)
            begin
                cal_offset <= cal_zero_value;
            end
            if (cal_mode != `ADCCAL_MODE_SYS_ZERO)
            begin
                cal_gain <= cal_full_value;
            end
        end
        else if (cal_busy && rate_tick)
        begin
            cal_left <= cal_left - 4'h1;
        end
        // Zero point measured in the first half of a combined sequence
        cal_zero_phase <= cal_busy && (cal_mode != `ADCCAL_MODE_SYS_FULL) &&
            ((cal_mode == `ADCCAL_MODE_SYS_ZERO) || ({cal_left, 1'b0} > {1'b0, cal_total}));
        cal_internal_src <= cal_busy && ((cal_mode == `ADCCAL_MODE_SELF) ||
            (cal_mode == `ADCCAL_MODE_BACKGROUND) ||
            (cal_mode == `ADCCAL_MODE_SYS_OFFSET && !cal_zero_phase));
    end
end

////////////////////////////////////////////////////////////////////////

// Serial read port, self-clocking only
always @(posedge core_clk)
begin
    if (!reset_n)
    begin
        state <= ST_IDLE;
        sclk_out <= 1'b1;
        sclk_oe <= 1'b0;
        serial_data_out <= 1'b0;
        serial_data_oe <= 1'b0;
        sample_ready_n <= 1'b1;
        bit_cnt <= 5'h00;
        bit_total <= 5'h00;
        shift <= 24'h000000;
        out_read <= 1'b0;
        half_cnt <= 3'h0;
    end
    else
    begin
        case (state)
            ST_IDLE:
            begin
                // External clocking is not built: frames need the mode pin high
                if (mode_sync && rfs_fall)
                begin
                    bit_cnt <= 5'h00;
                    half_cnt <= 3'h0;
                    if (!sel_sync)
                    begin
                        shift <= ctrl_reg;
                        bit_total <= `ADCCAL_BITS_24;
                        out_read <= 1'b0;
                        state <= ST_SHIFT;
                    end
                    else if (ctrl_reg[`ADCCAL_CTRL_CALRD_BIT])
                    begin
                        shift <= ctrl_reg[`ADCCAL_CTRL_CALFS_BIT] ? cal_gain : cal_offset;
                        bit_total <= `ADCCAL_BITS_24;
                        out_read <= 1'b0;
                        state <= ST_SHIFT;
                    end
                    else if (sample_ready_n)
                    begin
                        state <= ST_HOLD;
                    end
                    else
                    begin
                        shift <= wl24 ? out_reg : {out_reg[23:8], 8'h00};
                        bit_total <= wl24 ? `ADCCAL_BITS_24 : `ADCCAL_BITS_16;
                        out_read <= 1'b1;
                        state <= ST_SHIFT;
                    end
                    if (sel_sync && !ctrl_reg[`ADCCAL_CTRL_CALRD_BIT] && sample_ready_n)
                    begin
                        sclk_oe <= 1'b0;
                        serial_data_oe <= 1'b0;
                    end
                    else
                    begin
                        sclk_out <= 1'b1;
                        sclk_oe <= 1'b1;
                        serial_data_oe <= 1'b1;
                        serial_data_out <= !sel_sync ? ctrl_reg[23] :
                            ctrl_reg[`ADCCAL_CTRL_CALRD_BIT] ?
                            (ctrl_reg[`ADCCAL_CTRL_CALFS_BIT] ? cal_gain[23] : cal_offset[23]) :
                            out_reg[23];
                    end
                end
            end
            ST_SHIFT:
            begin
                // Strobe high mid-word pauses the clock and floats the data
                serial_data_oe <= !rfs_sync;
                if (!rfs_sync)
                begin
                    if (half_cnt == HALF_LAST)
                    begin
                        half_cnt <= 3'h0;
                        if (!sclk_out)
                        begin
                            sclk_out <= 1'b1;
                            bit_cnt <= bit_cnt + 5'h01;
                        end
                        else if (bit_cnt == bit_total)
                        begin
                            sclk_out <= 1'b0;
                            sclk_oe <= 1'b0;
                            serial_data_oe <= 1'b0;
                            state <= ST_HOLD;
                        end
                        else
                        begin
                            sclk_out <= 1'b0;
                            if (bit_cnt != 5'h00)
                            begin
                                shift <= {shift[22:0], 1'b0};
                                serial_data_out <= shift[22];
                            end
                        end
                    end
                    else
                    begin
                        half_cnt <= half_cnt + 3'h1;
                    end
                end
            end
            ST_HOLD:
            begin
                if (rfs_sync)
                begin
                    state <= ST_IDLE;
                end
            end
            default:
            begin
                state <= ST_IDLE;
            end
        endcase
        // Flag falls win over the rise so no event is lost
        if (state == ST_SHIFT && out_read && !rfs_sync && half_cnt == HALF_LAST &&
            sclk_out && bit_cnt == bit_total)
        begin
            sample_ready_n <= 1'b1;
        end
        if (cal_start && wr_mode != `ADCCAL_MODE_BACKGROUND)
        begin
            sample_ready_n <= 1'b1;
        end
        if (new_word)
        begin
            sample_ready_n <= 1'b0;
        end
        if (cal_done && cal_mode != `ADCCAL_MODE_BACKGROUND)
        begin
            sample_ready_n <= 1'b0;
        end
    end
end

endmodule

// file: adccal_props.sv
`timescale 1ns/10ps
`include "adccal_defines.vh"
module adccal_props #(
    parameter OUT_PERIOD_CYC = 40
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Watched pins
    input wire register_select,
    input wire reg_wr_en,
    input wire reg_wr_sel,
    input wire [23:0] reg_wr_data,
    input wire sclk_out,
    input wire sclk_oe,
    input wire serial_data_out,
    input wire serial_data_oe,
    input wire sample_ready_n,
    input wire [23:0] ctrl_reg,
    input wire cal_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    int busy_cnt;
    wire [2:0] mode = ctrl_reg[23:21];
    wire out_rd = register_select && !ctrl_reg[19];
    function automatic int dur(input logic [2:0] m);
        dur = (m == 3'h2 || m == 3'h3) ? 4 : (m == 3'h5) ? 6 : 9;
    endfunction
    // Tick phase is unknown, so the length is only known to within one period
    always @(posedge core_clk)
    begin
        if (!reset_n || !cal_busy)
            busy_cnt <= 0;
        else
            busy_cnt <= busy_cnt + 1;
    end
    ////////////////////////////////////////////////////////////////////////////
    a_reset_idle: assert property ($rose(reset_n) |-> sample_ready_n && !sclk_oe && ctrl_reg == 24'h000000)
        else $error("outputs not idle after reset");
    a_write_ctrl: assert property (reg_wr_en && !reg_wr_sel |=> ctrl_reg == $past(reg_wr_data))
        else $error("control write lost");
    a_cal_length: assert property ($fell(cal_busy) |->
        busy_cnt >= (dur(mode) - 1) * OUT_PERIOD_CYC && busy_cnt <= dur(mode) * OUT_PERIOD_CYC + 2)
        else $error("calibration length wrong");
    a_cal_done_flag: assert property ($fell(cal_busy) && mode != 3'h5 |-> ##[0:1] !sample_ready_n)
        else $error("calibration end not flagged");
    a_frame_start: assert property ($rose(sclk_oe) |-> sclk_out && serial_data_oe)
        else $error("frame start wrong");
    a_bits_on_fall: assert property (sclk_oe && $past(sclk_oe) && serial_data_out != $past(serial_data_out)
        |-> $fell(sclk_out))
        else $error("data changed off a falling edge");
    a_release_both: assert property ($fell(sclk_oe) |-> !serial_data_oe && !sclk_out && $past(sclk_out))
        else $error("release not on falling edge");
    a_output_flag: assert property (sclk_oe && out_rd |-> !sample_ready_n)
        else $error("output read with flag high");
    a_end_flag: assert property ($fell(sclk_oe) && out_rd |-> sample_ready_n)
        else $error("flag not raised after output read");
    a_reg_read_flag: assert property (sclk_oe && !out_rd |=> !$rose(sample_ready_n))
        else $error("register read moved flag");
endmodule
bind adccal_ctrl adccal_props #(.OUT_PERIOD_CYC(OUT_PERIOD_CYC)) u_props (.core_clk(core_clk),
    .reset_n(reset_n), .register_select(register_select), .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel),
    .reg_wr_data(reg_wr_data), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .sample_ready_n(sample_ready_n), .ctrl_reg(ctrl_reg), .cal_busy(cal_busy));

// file: adccal_host.sv
`timescale 1ns/10ps
module adccal_host (
    // Clock
    input wire core_clk,
    // Device driven lines
    input wire sclk_out,
    input wire sclk_oe,
    input wire serial_data_out,
    input wire serial_data_oe,
    // Host driven lines
    output logic read_frame_strobe_n,
    output logic register_select
);
    logic last_d = 1'b0;
    // Pull-up on the clock; undriven data shows the inverse of its last value
    wire sclk_line = sclk_oe ? sclk_out : 1'b1;
    wire data_line = serial_data_oe ? serial_data_out : ~last_d;
    always @(posedge core_clk)
    begin
        if (serial_data_oe)
            last_d <= serial_data_out;
    end
    initial
    begin
        read_frame_strobe_n = 1'b1;
        register_select = 1'b0;
    end
    // Flag is not looked at here, the caller decides when to read
    task automatic read_word(input logic sel, output logic [23:0] word, output int nbits);
        logic prev;
        int t;
        word = 24'h000000;
        nbits = 0;
        prev = 1'b1;
        @(posedge core_clk);
        #2 register_select = sel;
        repeat (5) @(posedge core_clk);
        #2 read_frame_strobe_n = 1'b0;
        for (t = 0; t < 400; t++)
        begin
            @(posedge core_clk);
            // Stop before the pull-up fakes a rising edge at release
            if (!sclk_oe && (nbits > 0 || t > 40))
                break;
            if (sclk_line && !prev)
            begin
                word = {word[22:0], data_line};
                nbits++;
            end
            prev = sclk_line;
        end
        #2 read_frame_strobe_n = 1'b1;
    endtask
endmodule

// file: adccal_ctrl_tb.sv
`timescale 1ns/10ps
`include "adccal_defines.vh"
module adccal_ctrl_tb;
    localparam int P = 40;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_wr_sel = 1'b0;
    logic [23:0] reg_wr_data = 24'h000000;
    logic result_valid = 1'b0;
    logic [23:0] result_data = 24'h000000;
    logic [23:0] cal_zero_value = 24'h000000;
    logic [23:0] cal_full_value = 24'h000000;
    logic mode_pin = 1'b1;
    wire zero_ph, int_src;
    wire strobe_n, sel, sclk_out, sclk_oe, sd_out, sd_oe, sample_ready_n, result_ready, cal_busy;
    wire [23:0] ctrl_reg;
    logic [23:0] w, v, last_w;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int m, n, k, nb, wl;
    adccal_ctrl #(.OUT_PERIOD_CYC(P)) dut (.core_clk(core_clk), .reset_n(reset_n),
        .read_frame_strobe_n(strobe_n), .register_select(sel), .mode_pin(mode_pin), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .serial_data_out(sd_out), .serial_data_oe(sd_oe), .sample_ready_n(sample_ready_n),
        .reg_wr_en(reg_wr_en), .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data), .result_valid(result_valid),
        .result_data(result_data), .result_ready(result_ready), .cal_zero_value(cal_zero_value),
        .cal_full_value(cal_full_value), .ctrl_reg(ctrl_reg), .cal_busy(cal_busy), .cal_zero_phase(zero_ph),
        .cal_internal_src(int_src));
    adccal_host host (.core_clk(core_clk), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .serial_data_out(sd_out),
        .serial_data_oe(sd_oe), .read_frame_strobe_n(strobe_n), .register_select(sel));
    ////////////////////////////////////////////////////////////////////////////
    function automatic int dur(input int md);
        dur = (md == 2 || md == 3) ? `ADCCAL_DUR_SYS_STEP : (md == 5) ? `ADCCAL_DUR_BACKGROUND : `ADCCAL_DUR_SELF;
    endfunction
    task automatic step(input int c);
        repeat (c)
        begin
            @(posedge core_clk);
            #2;
        end
    endtask
    task automatic check_val(input string name, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_range(input string name, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi)
        begin
            errors++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    task automatic write_reg(input logic s, input logic [23:0] d);
        reg_wr_sel = s;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        step(1);
        reg_wr_en = 1'b0;
    endtask
    task automatic print_verdict();
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever
        begin
            #20 core_clk = ~core_clk;
        end
    end
    // Run needs well under 10000 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            print_verdict();
        end
    end
    initial
    begin
        void'($urandom(22832));
        step(10);
        reset_n = 1'b1;
        step(1);
        check_val("ctrl reset", 24'h000000, ctrl_reg);
        check_val("flag reset", 24'h000001, {23'h0, sample_ready_n});
        // Calibrate first, every mode in turn
        for (m = 1; m <= 5; m++)
        begin
            cal_zero_value = $urandom;
            cal_full_value = $urandom;
            write_reg(1'b0, {m[2:0], 21'h000000});
            check_val("cal busy", 24'h000001, {23'h0, cal_busy});
            // Zero point first except in the full-scale step; during the zero phase only self and background use internal points
            step(2);
            check_val("zero phase", {23'h0, (m != 3)}, {23'h0, zero_ph});
            check_val("internal src", {23'h0, (m == 1 || m == 5)}, {23'h0, int_src});
            n = 2;
            while (cal_busy === 1'b1 && n < 1000)
            begin
                step(1);
                n++;
            end
            check_range("cal length", (dur(m) - 1) * P, dur(m) * P + 2, n);
            step(2);
            if (m != 5)
                check_val("cal flag", 24'h000000, {23'h0, sample_ready_n});
        end
        write_reg(1'b0, 24'h080000);
        host.read_word(1'b1, w, nb);
        check_val("offset", cal_zero_value, w);
        write_reg(1'b0, 24'h0C0000);
        host.read_word(1'b1, w, nb);
        check_val("gain", cal_full_value, w);
        v = $urandom;
        write_reg(1'b1, v);
        host.read_word(1'b1, w, nb);
        check_val("gain write", v, w);
        v = $urandom & 24'h1FFFFF;
        write_reg(1'b0, v);
        host.read_word(1'b0, w, nb);
        check_val("ctrl read", v, w);
        check_val("ctrl bits", 24'h000018, nb);
        for (wl = 0; wl < 2; wl++)
        begin
            write_reg(1'b0, {3'h0, wl[0], 20'h00000});
            result_valid = 1'b1;
            result_data = $urandom;
            n = 0;
            for (k = 0; k < 20 && n == 0; k++)
            begin
                @(posedge core_clk);
                if (result_ready === 1'b1)
                    last_w = result_data;
                else
                    n = k;
                #2 result_data = $urandom;
            end
            result_valid = 1'b0;
            check_range("fifo fill", 8, 9, n);
            step(11 * P);
            check_val("flag new", 24'h000000, {23'h0, sample_ready_n});
            // A word that lands mid-read must vanish
            fork
                host.read_word(1'b1, w, nb);
                begin
                    step(20);
                    result_valid = 1'b1;
                    step(1);
                    result_valid = 1'b0;
                end
            join
            check_val("out word", wl ? last_w : {8'h00, last_w[23:8]}, w);
            check_val("out bits", wl ? 24'h000018 : 24'h000010, nb);
            check_val("flag end", 24'h000001, {23'h0, sample_ready_n});
            host.read_word(1'b1, w, nb);
            check_val("refused", 24'h000000, nb);
            step(2 * P);
            check_val("flag dropped", 24'h000001, {23'h0, sample_ready_n});
        end
        // Mode pin low: no self-clocked frame may start
        mode_pin = 1'b0;
        step(3);
        host.read_word(1'b0, w, nb);
        check_val("mode low", 24'h000000, nb);
        print_verdict();
    end
endmodule
